// file: pelc_regs.v
// Serial management slave with event and line control registers.
`timescale 1ns/100ps
`include "pelc_consts.vh"
module pelc_regs #(
  parameter [4:0] PHY_ADDR = `PELC_PHY_ADDR
) (
  input wire core_clk,
  input wire rst_n,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe_n,
  input wire ev_jabber,
  input wire ev_rx_err,
  input wire ev_page_rx,
  input wire ev_pd_fault,
  input wire ev_lp_ack,
  input wire ev_link_down,
  input wire ev_remote_fault,
  input wire ev_link_up,
  input wire polarity_reversed,
  input wire mdix_state,
  input wire energy_present,
  input wire an_done,
  input wire pause_capable,
  input wire isolate_mode,
  input wire [2:0] op_mode,
  input wire cable_connected,
  input wire link_ok,
  input wire link_activity,
  input wire speed_100,
  output reg [1:0] lamp_mode,
  output reg first_status_lamp,
  output reg second_status_lamp,
  output reg remote_loopback,
  output reg vendor_crossover_algorithm_select,
  output reg mdix_force_swap,
  output reg auto_mdix_disable,
  output reg force_link,
  output reg rx_clk_enable,
  output reg jabber_cnt_en,
  output reg int_pin
);

  // ************************************************************
  // Frame state machine codes
  // ************************************************************
  localparam [2:0] S_PRE = 3'h0;
  localparam [2:0] S_HDR = 3'h1;
  localparam [2:0] S_TA_RD = 3'h2;
  localparam [2:0] S_RDATA = 3'h3;
  localparam [2:0] S_TA_WR = 3'h4;
  localparam [2:0] S_WDATA = 3'h5;
  localparam [2:0] S_SKIP = 3'h6;

  // ************************************************************
  // Declarations
  // ************************************************************
  wire mdc_s;
  wire mdio_s;
  reg mdc_d_r;
  wire mdc_rise;
  reg [2:0] st_r;
  reg [5:0] cnt_r;
  reg [12:0] hdr_r;
  reg [15:0] sh_r;
  reg [3:0] evt_en_r;
  reg [7:0] evt_flag_r;
  reg pol_lvl_r;
  reg psave_r;
  reg an_cmpl_r;
  reg an_done_d_r;
  wire [7:0] evt_in;
  wire hdr_last;
  wire frame_ok;
  wire addr_hit;
  wire rd_clear;
  reg wr_commit;
  wire [7:0] flag_set;

  // ************************************************************
  // Register read mux
  // ************************************************************
  function [15:0] rd_word;
    input [4:0] ra;
    begin
      case (ra)
        `PELC_REG_EVT: rd_word = {4'h0, evt_en_r, evt_flag_r};
        `PELC_REG_LAMP: rd_word = {
          lamp_mode,
          polarity_reversed,
          1'b0,
          mdix_state,
          3'h0,
          remote_loopback,
          7'h00};
        `PELC_REG_XOVR: rd_word = {
          vendor_crossover_algorithm_select,
          mdix_force_swap,
          auto_mdix_disable,
          energy_present,
          force_link,
          psave_r,
          pol_lvl_r,
          jabber_cnt_en,
          an_cmpl_r,
          pause_capable,
          isolate_mode,
          op_mode,
          2'h0};
        default: rd_word = 16'h0000;
      endcase
    end
  endfunction

  // ************************************************************
  // Link sampling
  // ************************************************************
  pelc_sync3 u_sync_mdc (
    .clk(core_clk),
    .rst_n(rst_n),
    .din(mdc),
    .dout(mdc_s)
  );

  pelc_sync3 u_sync_mdio (
    .clk(core_clk),
    .rst_n(rst_n),
    .din(mdio_in),
    .dout(mdio_s)
  );

  assign mdc_rise = mdc_s & ~mdc_d_r;
  // Clearing on the snapshot edge itself keeps an event of that cycle.
  assign rd_clear = mdc_rise && (st_r == S_TA_RD) &&
    (hdr_r[4:0] == `PELC_REG_EVT);
  assign hdr_last = (st_r == S_HDR) && (cnt_r == `PELC_HDR_BITS - 6'h01);
  assign frame_ok = hdr_r[11];
  assign addr_hit = (hdr_r[8:4] == PHY_ADDR);

  // ************************************************************
  // Frame decoder
  // ************************************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_d_r <= 1'b0;
      st_r <= S_PRE;
      cnt_r <= 6'h00;
      hdr_r <= 13'h0000;
      sh_r <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
      wr_commit <= 1'b0;
    end else begin
      mdc_d_r <= mdc_s;
      wr_commit <= 1'b0;
      if (mdc_rise) begin
        case (st_r)
          S_PRE: begin
            if (mdio_s) begin
              if (cnt_r != `PELC_PRE_BITS) begin
                cnt_r <= cnt_r + 6'h01;
              end
            end else if (cnt_r == `PELC_PRE_BITS) begin
              st_r <= S_HDR;
              cnt_r <= 6'h00;
            end else begin
              cnt_r <= 6'h00;
            end
          end
          S_HDR: begin
            hdr_r <= {hdr_r[11:0], mdio_s};
            cnt_r <= cnt_r + 6'h01;
            if (hdr_last) begin
              cnt_r <= 6'h00;
              if (!frame_ok || !addr_hit) begin
                st_r <= S_SKIP;
              end else if (hdr_r[10:9] == `PELC_OP_RD) begin
                st_r <= S_TA_RD;
              end else if (hdr_r[10:9] == `PELC_OP_WR) begin
                st_r <= S_TA_WR;
              end else begin
                st_r <= S_SKIP;
              end
            end
          end
          S_TA_RD: begin
            // Snapshot taken here is what the station collects.
            sh_r <= rd_word(hdr_r[4:0]);
            mdio_out <= 1'b0;
            mdio_oe_n <= 1'b0;
            st_r <= S_RDATA;
          end
          S_RDATA: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `PELC_DATA_BITS) begin
              mdio_out <= 1'b1;
              mdio_oe_n <= 1'b1;
              st_r <= S_PRE;
              cnt_r <= 6'h00;
            end else begin
              mdio_out <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
            end
          end
          S_TA_WR: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h01) begin
              st_r <= S_WDATA;
              cnt_r <= 6'h00;
            end
          end
          S_WDATA: begin
            sh_r <= {sh_r[14:0], mdio_s};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `PELC_DATA_BITS - 6'h01) begin
              wr_commit <= 1'b1;
              st_r <= S_PRE;
              cnt_r <= 6'h00;
            end
          end
          S_SKIP: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `PELC_DATA_BITS + 6'h01) begin
              st_r <= S_PRE;
              cnt_r <= 6'h00;
            end
          end
          default: begin
            st_r <= S_PRE;
            cnt_r <= 6'h00;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  assign evt_in = {ev_jabber, ev_rx_err, ev_page_rx, ev_pd_fault,
    ev_lp_ack, ev_link_down, ev_remote_fault, ev_link_up};
  assign flag_set = evt_in;

  // A new event in the clearing cycle survives the clear.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_flag_r <= 8'h00;
    end else if (rd_clear) begin
      evt_flag_r <= flag_set;
    end else begin
      evt_flag_r <= evt_flag_r | flag_set;
    end
  end

  // ************************************************************
  // Written control bits
  // ************************************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_en_r <= `PELC_RST_EN;
      lamp_mode <= `PELC_RST_LAMP;
      remote_loopback <= 1'b0;
      vendor_crossover_algorithm_select <= `PELC_RST_ALG;
      mdix_force_swap <= 1'b0;
      auto_mdix_disable <= 1'b0;
      force_link <= 1'b0;
      psave_r <= 1'b0;
      pol_lvl_r <= 1'b0;
      jabber_cnt_en <= `PELC_RST_JABEN;
      an_cmpl_r <= 1'b0;
      an_done_d_r <= 1'b0;
    end else begin
      an_done_d_r <= an_done;
      // Hardware progress overrides a stale software value.
      if (an_done != an_done_d_r) begin
        an_cmpl_r <= an_done;
      end
      if (wr_commit && hdr_r[4:0] == `PELC_REG_EVT) begin
        evt_en_r <= sh_r[`PELC_EVT_EN_HI:`PELC_EVT_EN_LO];
      end
      if (wr_commit && hdr_r[4:0] == `PELC_REG_LAMP) begin
        lamp_mode <= sh_r[`PELC_LAMP_HI:`PELC_LAMP_LO];
        remote_loopback <= sh_r[`PELC_LAMP_RLOOP];
      end
      if (wr_commit && hdr_r[4:0] == `PELC_REG_XOVR) begin
        vendor_crossover_algorithm_select <= sh_r[`PELC_XO_ALG];
        mdix_force_swap <= sh_r[`PELC_XO_SEL];
        auto_mdix_disable <= sh_r[`PELC_XO_DIS];
        force_link <= sh_r[`PELC_XO_FORCE];
        psave_r <= sh_r[`PELC_XO_PSAVE];
        pol_lvl_r <= sh_r[`PELC_XO_INTLVL];
        jabber_cnt_en <= sh_r[`PELC_XO_JABEN];
        if (an_done == an_done_d_r) begin
          an_cmpl_r <= sh_r[`PELC_XO_ANDONE];
        end
      end
    end
  end

  // ************************************************************
  // Line outputs
  // ************************************************************
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_pin <= 1'b1;
      rx_clk_enable <= 1'b1;
      first_status_lamp <= 1'b0;
      second_status_lamp <= 1'b0;
    end else begin
      // Only the lower four flags have enables; the rest never interrupt.
      int_pin <= (|(evt_flag_r[3:0] & evt_en_r)) ~^ pol_lvl_r;
      if (!psave_r) begin
        rx_clk_enable <= 1'b1;
      end else if (!cable_connected) begin
        rx_clk_enable <= 1'b0;
      end else if (link_ok) begin
        rx_clk_enable <= 1'b1;
      end
      case (lamp_mode)
        `PELC_LAMP_SPEED: begin
          second_status_lamp <= speed_100;
          first_status_lamp <= link_ok | link_activity;
        end
        `PELC_LAMP_ACT: begin
          second_status_lamp <= link_activity;
          first_status_lamp <= link_ok;
        end
        default: begin
          // Reserved codes leave both lamps dark.
          second_status_lamp <= 1'b0;
          first_status_lamp <= 1'b0;
        end
      endcase
    end
  end

  // Read-only status bits come straight from the datapath.
  // Energy, pause, isolate and mode are read live.
  // Mode code is passed through unchanged.

endmodule // pelc_regs

// file: pelc_consts.vh
// Constants of the event and line control management registers.
`ifndef PELC_CONSTS_VH
`define PELC_CONSTS_VH

// ************************************************************
// Register addresses
// ************************************************************
`define PELC_REG_EVT 5'h1b
`define PELC_REG_LAMP 5'h1e
`define PELC_REG_XOVR 5'h1f

// ************************************************************
// Field positions
// ************************************************************
`define PELC_EVT_EN_HI 11
`define PELC_EVT_EN_LO 8
`define PELC_LAMP_HI 15
`define PELC_LAMP_LO 14
`define PELC_LAMP_POL 13
`define PELC_LAMP_MDIX 11
`define PELC_LAMP_RLOOP 7
`define PELC_XO_ALG 15
`define PELC_XO_SEL 14
`define PELC_XO_DIS 13
`define PELC_XO_ENERGY 12
`define PELC_XO_FORCE 11
`define PELC_XO_PSAVE 10
`define PELC_XO_INTLVL 9
`define PELC_XO_JABEN 8
`define PELC_XO_ANDONE 7
`define PELC_XO_PAUSE 6
`define PELC_XO_ISO 5
`define PELC_XO_MODE_HI 4
`define PELC_XO_MODE_LO 2

// ************************************************************
// Reset values and codes
// ************************************************************
`define PELC_RST_EN 4'h0
`define PELC_RST_LAMP 2'h0
`define PELC_RST_ALG 1'b1
`define PELC_RST_JABEN 1'b1
`define PELC_LAMP_SPEED 2'h0
`define PELC_LAMP_ACT 2'h1

// ************************************************************
// Management frame
// ************************************************************
`define PELC_PRE_BITS 6'h20
`define PELC_HDR_BITS 6'h0d
`define PELC_DATA_BITS 6'h10
`define PELC_OP_RD 2'h2
`define PELC_OP_WR 2'h1
`define PELC_PHY_ADDR 5'h01

`endif

// file: pelc_sync3.v
// Three flip-flop synchroniser with agreement filter.
`timescale 1ns/100ps
module pelc_sync3 (
  input wire clk,
  input wire rst_n,
  input wire din,
  output reg dout
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // The first stage is read only by the second one.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end

endmodule // pelc_sync3

// file: pelc_regs_props.sv
// Port assertions of the management register block.
`timescale 1ns/100ps
module pelc_regs_props (
  input wire core_clk,
  input wire rst_n,
  input wire mdc,
  input wire mdio_out,
  input wire mdio_oe_n,
  input wire cable_connected,
  input wire link_ok,
  input wire link_activity,
  input wire speed_100,
  input wire [1:0] lamp_mode,
  input wire first_status_lamp,
  input wire second_status_lamp,
  input wire remote_loopback,
  input wire vendor_crossover_algorithm_select,
  input wire mdix_force_swap,
  input wire auto_mdix_disable,
  input wire force_link,
  input wire rx_clk_enable,
  input wire jabber_cnt_en,
  input wire int_pin
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reg mdc_q_r;
  reg [4:0] rises_r;
  wire [7:0] ctl = {lamp_mode, remote_loopback,
    vendor_crossover_algorithm_select, mdix_force_swap, auto_mdix_disable,
    force_link, jabber_cnt_en};
  // Counts raw clock rises while the device drives, to size a read answer.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q_r <= 1'b0;
      rises_r <= 5'h00;
    end else begin
      mdc_q_r <= mdc;
      if (mdio_oe_n)
        rises_r <= 5'h00;
      else if (mdc && !mdc_q_r)
        rises_r <= rises_r + 5'h01;
    end
  end
  sequence s_ta_start;
    $fell(mdio_oe_n);
  endsequence
  sequence s_drive_end;
    $rose(mdio_oe_n);
  endsequence
  a_release_high: assert property (mdio_oe_n |-> mdio_out)
    else $error("released data line not high");
  a_ta_zero: assert property (s_ta_start |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_read_len: assert property (s_drive_end |-> rises_r == 5'h11)
    else $error("read answer length wrong");
  a_reg_quiet: assert property ($changed(ctl) |-> mdio_oe_n)
    else $error("control changed during a read");
  a_reset_vals: assert property ($rose(rst_n) |->
    ctl == 8'h11 && rx_clk_enable && int_pin && mdio_oe_n)
    else $error("reset values wrong");
  a_first_lamp: assert property ($past(rst_n) |->
    first_status_lamp == ($past(lamp_mode) == 2'h0 ?
    $past(link_ok) | $past(link_activity) :
    $past(lamp_mode) == 2'h1 && $past(link_ok)))
    else $error("first lamp wrong");
  a_second_lamp: assert property ($past(rst_n) |->
    second_status_lamp == ($past(lamp_mode) == 2'h0 ? $past(speed_100) :
    $past(lamp_mode) == 2'h1 && $past(link_activity)))
    else $error("second lamp wrong");
  a_rxclk_drop: assert property ($fell(rx_clk_enable) |->
    !$past(cable_connected))
    else $error("receive clock stopped with cable present");
endmodule // pelc_regs_props
bind pelc_regs pelc_regs_props props_u (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .mdc(mdc),
  .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n),
  .cable_connected(cable_connected),
  .link_ok(link_ok),
  .link_activity(link_activity),
  .speed_100(speed_100),
  .lamp_mode(lamp_mode),
  .first_status_lamp(first_status_lamp),
  .second_status_lamp(second_status_lamp),
  .remote_loopback(remote_loopback),
  .vendor_crossover_algorithm_select(vendor_crossover_algorithm_select),
  .mdix_force_swap(mdix_force_swap),
  .auto_mdix_disable(auto_mdix_disable),
  .force_link(force_link),
  .rx_clk_enable(rx_clk_enable),
  .jabber_cnt_en(jabber_cnt_en),
  .int_pin(int_pin)
);

// file: pelc_station.sv
// Station model that runs management frames on the serial pins.
`timescale 1ns/100ps
module pelc_station (
  output reg mdc,
  output wire mdio_line,
  input wire mdio_out,
  input wire mdio_oe_n
);
  reg drv = 1'b0;
  reg dat = 1'b1;
  // The line has a pull-up, so a line nobody drives reads high.
  assign mdio_line = !mdio_oe_n ? mdio_out : drv ? dat : 1'b1;
  initial mdc = 1'b0;
  task automatic xfer(input [4:0] pa, input w, input [4:0] ra,
    input [15:0] wd, output [15:0] rd);
    reg [63:0] f;
    integer i;
    begin
      f = {32'hffffffff, 2'b01, !w, w, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      #1.3;
      for (i = 63; i >= 0; i = i - 1) begin
        drv = w || i > 17;
        dat = f[i];
        #16 mdc = 1'b1;
        if (i < 16)
          rd[i] = mdio_line;
        #16 mdc = 1'b0;
      end
      drv = 1'b0;
    end
  endtask
endmodule // pelc_station

// file: test_phy_event_and_line_control_regs.sv
// Self-checking bench of the event and line control registers.
`timescale 1ns/100ps
`include "pelc_consts.vh"
module test_phy_event_and_line_control_regs;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] ev = 8'h00;
  reg [11:0] s = 12'h300;
  reg an = 1'b0;
  reg [31:0] rs = 32'h561b47d2;
  reg [3:0] men = 4'h0;
  reg [7:0] mf = 8'h00;
  reg [15:0] m1e = 16'h0000;
  reg [15:0] m1f = 16'h8100;
  reg [15:0] rdv, e, x;
  reg [2:0] tb;
  integer failures = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer i, k;
  wire mdc, mdio_in, mdio_out, mdio_oe_n, l0, l1, rxen, int_pin;
  wire [1:0] lm;
  wire [5:0] c;
  pelc_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .ev_jabber(ev[7]), .ev_rx_err(ev[6]), .ev_page_rx(ev[5]),
    .ev_pd_fault(ev[4]), .ev_lp_ack(ev[3]), .ev_link_down(ev[2]),
    .ev_remote_fault(ev[1]), .ev_link_up(ev[0]),
    .polarity_reversed(s[0]), .mdix_state(s[1]), .energy_present(s[2]),
    .an_done(an), .pause_capable(s[3]), .isolate_mode(s[4]),
    .op_mode(s[7:5]), .cable_connected(s[8]), .link_ok(s[9]),
    .link_activity(s[10]), .speed_100(s[11]), .lamp_mode(lm),
    .first_status_lamp(l0), .second_status_lamp(l1),
    .remote_loopback(c[5]), .vendor_crossover_algorithm_select(c[4]),
    .mdix_force_swap(c[3]), .auto_mdix_disable(c[2]), .force_link(c[1]),
    .rx_clk_enable(rxen), .jabber_cnt_en(c[0]), .int_pin(int_pin));
  pelc_station st_u (.mdc(mdc), .mdio_line(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [4:0] ad(input integer n);
    ad = n == 0 ? `PELC_REG_EVT : 5'h1d + n[4:0];
  endfunction
  function [15:0] exp_rd(input [4:0] a);
    case (a)
      `PELC_REG_EVT: exp_rd = {4'h0, men, mf};
      `PELC_REG_LAMP: exp_rd = (m1e & 16'hc080) | {2'h0, s[0], 1'b0, s[1],
        11'h0};
      `PELC_REG_XOVR: exp_rd = (m1f & 16'hef80) | {3'h0, s[2], 5'h0, s[3],
        s[4], s[7:5], 2'h0};
      default: exp_rd = 16'h0000;
    endcase
  endfunction
  task chk(input [63:0] nm, input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Event register reads clear the model flags at once; no event is raised mid-frame.
  task fr(input [4:0] pa, input [4:0] a, input w, input [15:0] d);
    begin
      e = exp_rd(a);
      st_u.xfer(pa, w, a, d, rdv);
      if (!w && a == `PELC_REG_EVT)
        mf = 8'h00;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task rd(input [4:0] a);
    fr(`PELC_PHY_ADDR, a, 1'b0, 16'h0000);
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      fr(`PELC_PHY_ADDR, a, 1'b1, d);
      if (a == `PELC_REG_EVT)
        men = d[11:8];
      if (a == `PELC_REG_LAMP)
        m1e = d;
      if (a == `PELC_REG_XOVR)
        m1f = d;
    end
  endtask
  task outs;
    reg f0, f1, ip;
    begin
      f0 = m1e[15:14] == 2'h0 ? s[9] | s[10] : m1e[15:14] == 2'h1 && s[9];
      f1 = m1e[15:14] == 2'h0 ? s[11] : m1e[15:14] == 2'h1 && s[10];
      ip = |(mf[3:0] & men);
      x = {8'h0, m1e[15:14], m1e[7], m1f[15:13], m1f[11], m1f[8]};
      chk("lamps", {14'h0, l0, l1}, {14'h0, f0, f1});
      chk("ctl", {8'h0, lm, c}, x);
      chk("int", {15'h0, int_pin}, {15'h0, m1f[9] ? ip : !ip});
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 3; i = i + 1) begin
      rd(ad(i));
      chk("reset", rdv, e);
    end
    outs;
    $display("reset value test done");
    for (i = 0; i < 12; i = i + 1) begin
      rs = xs(rs);
      @(posedge core_clk);
      s <= rs[11:0];
      wr(ad(i % 3), rs[31:16]);
      outs;
      rd(ad(i % 3));
      chk("rdback", rdv, e);
    end
    $display("register access test done");
    wr(`PELC_REG_EVT, 16'h0f00);
    wr(`PELC_REG_XOVR, m1f | 16'h0200);
    for (k = 0; k < 9; k = k + 1) begin
      if (k == 8)
        wr(`PELC_REG_XOVR, m1f & 16'hfdff);
      @(posedge core_clk);
      ev <= 8'h01 << k[2:0];
      mf[k[2:0]] = 1'b1;
      @(posedge core_clk);
      ev <= 8'h00;
      repeat (3) @(posedge core_clk);
      outs;
      rd(`PELC_REG_EVT);
      chk("flags", rdv, e);
      outs;
      rd(`PELC_REG_EVT);
      chk("cleared", rdv, e);
    end
    $display("event test done");
    @(posedge core_clk);
    an <= 1'b1;
    m1f[7] = 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`PELC_REG_XOVR);
    chk("andone", rdv, e);
    fr(5'h02, `PELC_REG_LAMP, 1'b1, ~m1e);
    rd(`PELC_REG_LAMP);
    chk("refuse", rdv, e);
    rd(5'h10);
    chk("unmapped", rdv, e);
    $display("refusal test done");
    @(posedge core_clk);
    s[9:8] <= 2'h3;
    wr(`PELC_REG_XOVR, m1f | 16'h0400);
    chk("rxclk", {15'h0, rxen}, 16'h0001);
    for (k = 0; k < 3; k = k + 1) begin
      tb = 9'h1e2 >> (3 * k);
      @(posedge core_clk);
      s[9:8] <= {tb[1], tb[2]};
      repeat (4) @(posedge core_clk);
      chk("rxclk", {15'h0, rxen}, {15'h0, tb[0]});
    end
    $display("power saving test done");
    final_report;
  end
  // The ceiling leaves about twice the expected run length.
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 55000) begin
      failures = failures + 1;
      final_report;
    end
  end
endmodule // test_phy_event_and_line_control_regs
